// ---- design/sct_decoder.sv ----
// instruction length and cycle timing decoder with occupancy sequencer
// assumes opcode and wait count come from logic on the same core clock
//
// Function
// - add, add-carry, subtract-borrow with register: one byte, one cycle
// - add/subtract with pointer-indirect operand: one byte, two cycles
// - add/subtract with direct or immediate operand: two bytes, two cycles
// - multiply accumulator by auxiliary register: one byte, four cycles
// - divide: one byte, nine cycles; decimal adjust: one byte, two cycles
// - inc/dec of accumulator or register 1/1; indirect forms 1/2
// - decrement of direct byte: two bytes, two cycles
// - and/or/xor register into accumulator: one byte, one cycle
// - and/or/xor indirect into accumulator: one byte, two cycles
// - logic immediate into direct byte 3/3; other direct/immediate 2/2
// - clear, complement, swap and rotates of accumulator: 1/1
// - accumulator to/from indirect 1/2; register to accumulator 1/1
// - direct-to-direct move and immediate to direct: three bytes, three
// - load data pointer immediate: three bytes, three cycles
// - code-memory reads relative to pointer or counter: 1/4
// - external data moves, any address width or direction: 1/4 base
// - each external-move wait state adds exactly one cycle
// - push/pop direct 2/2; exchange indirect or its nibble 1/2
// - direct-bit operations including carry combine and store: 2/2
// - indirect jump 1/3; subroutine and interrupt return 1/4
// - absolute call and absolute jump: two bytes, three cycles
// - each counted cycle is exactly one core clock period
`timescale 1ns/1ps

module sct_decoder
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic opcode_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [sct_pkg::WAIT_W-1:0] external_move_wait_count_i,
  output logic accepted_o,
  output logic busy_o,
  output logic next_fetch_o,
  output logic known_o,
  output logic [1:0] insn_len_o,
  output logic [3:0] insn_cycles_o
);
  import sct_pkg::*;

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;

  // reset release through two flops so every register on rst_n leaves reset together
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  // builds one table entry
  function automatic sct_timing_t ent(input logic [1:0] l,
                                      input logic [3:0] c);
    sct_timing_t t;
    t.known = 1'b1;
    t.ext_move = 1'b0;
    t.len = l;
    t.cyc = c;
    return t;
  endfunction

  // opcode to length and base cycles; rows absent from the table decode as
  // unknown with a safe one-byte, one-cycle default
  function automatic sct_timing_t lookup(input logic [7:0] op);
    sct_timing_t t;
    t = TIMING_RST;
    casez (op)
      // arithmetic
      // add register to accumulator
      8'b0010_1???:
        t = ent(LEN_ONE, CYC_ONE);
      // add register with carry
      8'b0011_1???:
        t = ent(LEN_ONE, CYC_ONE);
      // subtract register with borrow
      8'b1001_1???:
        t = ent(LEN_ONE, CYC_ONE);
      // add pointer-indirect operand
      8'b0010_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // add pointer-indirect operand with carry
      8'b0011_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // subtract pointer-indirect operand with borrow
      8'b1001_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // add immediate or direct byte
      8'h24, 8'h25:
        t = ent(LEN_TWO, CYC_TWO);
      // add-carry immediate or direct byte
      8'h34, 8'h35:
        t = ent(LEN_TWO, CYC_TWO);
      // subtract-borrow immediate or direct byte
      8'h94, 8'h95:
        t = ent(LEN_TWO, CYC_TWO);
      // multiply accumulator by auxiliary register
      8'ha4:
        t = ent(LEN_ONE, CYC_FOUR);
      // divide; the longest fixed occupancy in the table
      8'h84:
        t = ent(LEN_ONE, CYC_NINE);
      // decimal adjust of the accumulator
      8'hd4:
        t = ent(LEN_ONE, CYC_TWO);
      // increment and decrement of the accumulator
      8'h04, 8'h14:
        t = ent(LEN_ONE, CYC_ONE);
      // increment and decrement of a working register
      8'b0000_1???, 8'b0001_1???:
        t = ent(LEN_ONE, CYC_ONE);
      // indirect increment and decrement need a memory turn
      8'b0000_011?, 8'b0001_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // decrement of a direct byte
      8'h15:
        t = ent(LEN_TWO, CYC_TWO);
      // logic
      // or register into accumulator
      8'b0100_1???:
        t = ent(LEN_ONE, CYC_ONE);
      // and register into accumulator
      8'b0101_1???:
        t = ent(LEN_ONE, CYC_ONE);
      // exclusive-or register into accumulator
      8'b0110_1???:
        t = ent(LEN_ONE, CYC_ONE);
      // or indirect into accumulator
      8'b0100_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // and indirect into accumulator
      8'b0101_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // exclusive-or indirect; one byte like its siblings, the opcode
      // carries no operand byte
      8'b0110_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // immediate data into a direct byte
      8'h43, 8'h53, 8'h63:
        t = ent(LEN_THREE, CYC_THREE);
      // accumulator with direct byte or immediate
      8'h44, 8'h45, 8'h54, 8'h55, 8'h64, 8'h65:
        t = ent(LEN_TWO, CYC_TWO);
      // accumulator into a direct byte
      8'h42, 8'h52, 8'h62:
        t = ent(LEN_TWO, CYC_TWO);
      // clear, complement and nibble swap
      8'he4, 8'hf4, 8'hc4:
        t = ent(LEN_ONE, CYC_ONE);
      // the four rotates, with and without carry
      8'h23, 8'h33, 8'h03, 8'h13:
        t = ent(LEN_ONE, CYC_ONE);
      // data transfer
      // register to or from accumulator, exchange with register
      8'b1110_1???, 8'b1111_1???, 8'b1100_1???:
        t = ent(LEN_ONE, CYC_ONE);
      // accumulator to or from pointer-indirect memory
      8'b1110_011?, 8'b1111_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // remaining one-operand moves and exchange with a direct byte
      8'he5, 8'h74, 8'hf5, 8'b0111_1???, 8'b1010_1???, 8'b1000_1???,
      8'b0111_011?, 8'b1000_011?, 8'b1010_011?, 8'hc5:
        t = ent(LEN_TWO, CYC_TWO);
      // direct to direct and immediate to direct
      8'h85, 8'h75:
        t = ent(LEN_THREE, CYC_THREE);
      // data pointer load
      8'h90:
        t = ent(LEN_THREE, CYC_THREE);
      // code-memory reads
      8'h93, 8'h83:
        t = ent(LEN_ONE, CYC_FOUR);
      // external moves; wait states are added outside the table
      8'he0, 8'hf0, 8'b1110_001?, 8'b1111_001?:
      begin
        t = ent(LEN_ONE, CYC_EXT_BASE);
        t.ext_move = 1'b1;
      end
      // stack push and pop
      8'hc0, 8'hd0:
        t = ent(LEN_TWO, CYC_TWO);
      // exchange with indirect memory or its low nibble
      8'b1100_011?, 8'b1101_011?:
        t = ent(LEN_ONE, CYC_TWO);
      // boolean
      // carry-only operations
      8'hc3, 8'hd3, 8'hb3:
        t = ent(LEN_ONE, CYC_ONE);
      // operations naming a direct bit
      8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92:
        t = ent(LEN_TWO, CYC_TWO);
      // branching
      // indirect jump
      8'h73:
        t = ent(LEN_ONE, CYC_THREE);
      // subroutine and interrupt return
      8'h22, 8'h32:
        t = ent(LEN_ONE, CYC_FOUR);
      // absolute call and jump, page bits in the upper three
      8'b???1_0001, 8'b???0_0001:
        t = ent(LEN_TWO, CYC_THREE);
      default:
        t = TIMING_RST;
    endcase
    return t;
  endfunction

  sct_timing_t base_w;
  sct_timing_t final_w;
  logic [3:0] wait_ext_w;
  logic accept_w;
  logic last_w;

  logic busy_reg;
  logic busy_next;
  logic [3:0] remain_reg;
  logic [3:0] remain_next;
  logic fetch_reg;
  logic fetch_next;
  logic accepted_reg;
  sct_timing_t cur_reg;
  sct_timing_t cur_next;

  // decode and wait-state extension; wait count is sampled at accept only
  assign base_w = lookup(opcode_i);
  assign wait_ext_w = {1'b0, external_move_wait_count_i};
  assign final_w.known = base_w.known;
  assign final_w.ext_move = base_w.ext_move;
  assign final_w.len = base_w.len;
  assign final_w.cyc = base_w.ext_move ? base_w.cyc + wait_ext_w
                                       : base_w.cyc;

  // a new opcode is taken only when the previous one has fully elapsed
  assign accept_w = opcode_valid_i && !busy_reg;
  assign last_w = busy_reg && (remain_reg == CYC_ONE);

  // next-state selection
  assign cur_next = accept_w ? final_w : cur_reg;
  assign remain_next = accept_w ? final_w.cyc
                     : busy_reg ? remain_reg - CYC_ONE
                     : remain_reg;
  assign busy_next = accept_w ? 1'b1 : (last_w ? 1'b0 : busy_reg);
  assign fetch_next = last_w;

  // occupancy flag; high from the take until the last counted cycle
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      busy_reg <= 1'b0;
    else
      busy_reg <= busy_next;
  end

  // remaining cycles; one decrement per core clock, never skipped
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      remain_reg <= REMAIN_RST;
    else
      remain_reg <= remain_next;
  end

  // fetch pulse, one cycle wide
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      fetch_reg <= 1'b0;
    else
      fetch_reg <= fetch_next;
  end

  // take pulse, one cycle wide
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      accepted_reg <= 1'b0;
    else
      accepted_reg <= accept_w;
  end

  // latched timing entry; stands until the next take
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      cur_reg <= TIMING_RST;
    else
      cur_reg <= cur_next;
  end

  // all outputs straight from flops
  assign accepted_o = accepted_reg;
  assign busy_o = busy_reg;
  assign next_fetch_o = fetch_reg;
  assign known_o = cur_reg.known;
  assign insn_len_o = cur_reg.len;
  assign insn_cycles_o = cur_reg.cyc;

endmodule

// ---- shared/sct_pkg.sv ----
// package for the single-cycle instruction timing decoder
// assumes one core clock; every timing figure is counted in core clocks
package sct_pkg;

  // core clock figure; one counted cycle is one period of it
  localparam int CLK_PERIOD_NS = 5;

  // instruction byte lengths
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // execution cycle counts
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR = 4'h4;
  localparam logic [3:0] CYC_NINE = 4'h9;
  // external move base count, before wait states are added
  localparam logic [3:0] CYC_EXT_BASE = 4'h4;

  // wait-state field width (0 to 7 wait states)
  localparam int WAIT_W = 3;

  // reset values
  localparam logic [3:0] REMAIN_RST = 4'h0;

  // one decoded timing entry
  typedef struct packed {
    logic known;
    logic ext_move;
    logic [1:0] len;
    logic [3:0] cyc;
  } sct_timing_t;

  localparam sct_timing_t TIMING_RST = '{
    known: 1'b0, ext_move: 1'b0, len: 2'h1, cyc: 4'h1};

endpackage

// ---- verification/sct_decoder_chk.sv ----
// port assertions for the timing decoder
// assumes it is bound into sct_decoder
`timescale 1ns/1ps
module sct_decoder_chk
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic opcode_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [sct_pkg::WAIT_W-1:0] external_move_wait_count_i,
  input wire logic accepted_o,
  input wire logic busy_o,
  input wire logic next_fetch_o,
  input wire logic known_o,
  input wire logic [1:0] insn_len_o,
  input wire logic [3:0] insn_cycles_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // a take needs an idle request one edge earlier
  take_cause_a: assert property (accepted_o |->
    $past(opcode_valid_i && !busy_o)) else $error("take without request");
  take_pulse_a: assert property (accepted_o |=> !accepted_o)
    else $error("take pulse too long");
  one_cycle_a: assert property (accepted_o && insn_cycles_o == 4'h1
    |=> next_fetch_o && !busy_o) else $error("one cycle late");
  two_cycle_a: assert property (accepted_o && insn_cycles_o == 4'h2
    |=> busy_o ##1 next_fetch_o) else $error("two cycle wrong");
  div_busy_a: assert property (accepted_o && $past(opcode_i) == 8'h84
    |-> insn_cycles_o == 4'h9 ##1 busy_o [*8] ##1 next_fetch_o)
    else $error("divide occupancy wrong");
  mul_time_a: assert property (accepted_o && $past(opcode_i) == 8'ha4
    |-> insn_len_o == 2'h1 && insn_cycles_o == 4'h4)
    else $error("multiply timing wrong");
  ext_wait_a: assert property (accepted_o && $past(opcode_i) == 8'he0
    |-> insn_cycles_o == 4'h4 + $past(external_move_wait_count_i))
    else $error("wait states not added");
  fetch_idle_a: assert property (next_fetch_o |-> !busy_o && !accepted_o)
    else $error("fetch while occupied");
  hold_out_a: assert property (!accepted_o |-> $stable(insn_cycles_o)
    && $stable(known_o)) else $error("timing changed between takes");
  cover property (accepted_o && insn_cycles_o == 4'h9);
  cover property (accepted_o && insn_cycles_o == 4'hb);
  cover property (accepted_o && !known_o);
endmodule

// ---- verification/sct_fetch_model.sv ----
// program fetch side: one opcode per request from the bench
// assumes go_i is held until the decoder shows its take pulse
`timescale 1ns/1ps
module sct_fetch_model
(
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [7:0] op_i,
  input wire logic [2:0] wait_i,
  input wire logic taken_i,
  output logic valid_o = 1'b0,
  output logic [7:0] opcode_o = 8'h00,
  output logic [2:0] wait_o = 3'h0
);
  // released byte is inverted so a stale opcode cannot look valid
  always @(posedge mclk_i)
  begin
    if (taken_i)
    begin
      valid_o <= 1'b0;
      opcode_o <= ~opcode_o;
    end
    else if (go_i && !valid_o)
    begin
      valid_o <= 1'b1;
      opcode_o <= op_i;
      wait_o <= wait_i;
    end
  end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the timing decoder
// assumes checker and fetch model are compiled first
`timescale 1ns/1ps
module tb;
  // rows: opcode, length, cycles
  localparam logic [15:0] TBL [27] = '{
    16'h2811, 16'h3612, 16'h9422, 16'ha414, 16'h8419,
    16'hd412, 16'h0411, 16'h0612, 16'h1522, 16'h5811,
    16'h4612, 16'h6612, 16'h5333, 16'h6222, 16'he411,
    16'h3311, 16'he612, 16'h8533, 16'h9033, 16'h9314,
    16'he014, 16'hc022, 16'hd612, 16'h9222, 16'h7313,
    16'h3214, 16'h1123};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic go = 1'b0;
  logic [7:0] fop = 8'h00;
  logic [2:0] fw = 3'h0;
  logic valid, accepted_o, busy_o, next_fetch_o, known_o;
  logic [7:0] opc;
  logic [2:0] wcnt;
  logic [1:0] len;
  logic [3:0] cyc;
  int n_fail = 0;
  int n_checks = 0;
  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  sct_fetch_model fm (.mclk_i, .go_i(go), .op_i(fop), .wait_i(fw),
    .taken_i(accepted_o), .valid_o(valid), .opcode_o(opc), .wait_o(wcnt));
  sct_decoder dut (.mclk_i, .rst_n_i, .opcode_valid_i(valid),
    .opcode_i(opc), .external_move_wait_count_i(wcnt), .accepted_o,
    .busy_o, .next_fetch_o, .known_o, .insn_len_o(len),
    .insn_cycles_o(cyc));
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic stuck();
    n_fail++;
    give_verdict();
  endtask
  // one request, then count edges until the fetch pulse
  task automatic run(logic [7:0] op, logic [2:0] w, logic [1:0] el,
    logic [3:0] ec, logic ek);
    int c;
    c = 0;
    @(posedge mclk_i);
    go <= 1'b1;
    fop <= op;
    fw <= w;
    while (accepted_o !== 1'b1 && c < 20)
    begin
      @(posedge mclk_i);
      #1;
      c++;
    end
    if (accepted_o !== 1'b1) stuck();
    chk("length", len, el);
    chk("cycles", cyc, ec);
    chk("known", known_o, ek);
    c = 0;
    while (next_fetch_o !== 1'b1 && c < 20)
    begin
      @(posedge mclk_i);
      go <= 1'b0;
      #1;
      c++;
    end
    if (next_fetch_o !== 1'b1) stuck();
    chk("occupancy", c, ec);
  endtask
  task automatic t_table();
    for (int i = 0; i < 27; i++)
      run(TBL[i][15:8], 3'h0, TBL[i][5:4], TBL[i][3:0], 1'b1);
    $display("table test done");
  endtask
  // each wait count 0 to 7 once, rotating through the six external moves; others ignore it
  task automatic t_wait();
    logic [7:0] ext [6] = '{8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
    for (int w = 0; w < 8; w++)
      run(ext[w % 6], 3'(w), 2'h1, 4'(4 + w), 1'b1);
    run(8'h25, 3'h7, 2'h2, 4'h2, 1'b1);
    run(8'h00, 3'h5, 2'h1, 4'h1, 1'b0);
    $display("wait test done");
  endtask
  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    t_table();
    t_wait();
    give_verdict();
  end
endmodule
bind sct_decoder sct_decoder_chk chk (.mclk_i, .rst_n_i, .opcode_valid_i,
  .opcode_i, .external_move_wait_count_i, .accepted_o, .busy_o,
  .next_fetch_o, .known_o, .insn_len_o, .insn_cycles_o);
